/* core/afc_pkg.sv */
/*
 * Shared constants and types of the serial audio framer: register map,
 * field positions, reset values and mode encodings.
 * Assumes a 32-bit Avalon-MM register bus with byte addresses.
 */
package afc_pkg;
    // Register byte offsets
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_PSC  = 4'h4;
    localparam logic [3:0] OFS_DATA = 4'h8;
    localparam logic [3:0] OFS_STAT = 4'hC;
    // Audio control register fields
    localparam int C_EN  = 0;
    localparam int C_STD = 1;
    localparam int C_DL  = 3;
    localparam int C_CL  = 5;
    localparam int C_POL = 6;
    localparam int C_FSL = 7;
    localparam logic [7:0] CTRL_RST = 8'h00;
    // Audio prescaler register fields
    localparam int P_DIV = 0;
    localparam int P_ODD = 8;
    localparam int P_MCK = 9;
    localparam logic [7:0] DIV_RST = 8'h02;
    // Status register fields
    localparam int S_TXE  = 0;
    localparam int S_RXR  = 1;
    localparam int S_BUSY = 2;
    localparam int S_SIDE = 3;
    // Bit counts and minimum divisor
    localparam logic [5:0] BITS16 = 6'h10;
    localparam logic [5:0] BITS24 = 6'h18;
    localparam logic [5:0] BITS32 = 6'h20;
    localparam logic [5:0] LONG_SYNC_BITS = 6'h0D;
    localparam logic [8:0] MIN_DIV = 9'h002;
    typedef enum logic [1:0] {
        STD_PHILIPS = 2'h0,
        STD_MSB     = 2'h1,
        STD_LSB     = 2'h2,
        STD_PCM     = 2'h3
    } afc_std_t;
    typedef enum logic [1:0] {
        DL_16 = 2'h0,
        DL_24 = 2'h1,
        DL_32 = 2'h2
    } afc_dlen_t;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b01,
        BUS_ACK  = 2'b10
    } afc_bus_t;
endpackage : afc_pkg

/* core/afc_audio_serial.sv */
/*
 * Serial audio master: framing for MSB-, LSB-justified and PCM formats,
 * clock generation and a 16-bit data port behind Avalon-MM registers.
 * Assumes one clock, serial data input synchronous to it.
 */
// Our own choices: the placing of the registers and register access over Avalon-MM.
// How it works
// - MSB-justified: word select and data change on falling bit clock.
// - LSB-justified: word select and data change on falling bit clock.
// - PCM: change on rising bit clock; word select marks frames.
// - MSB and PCM split samples into halfwords like Philips format.
// - Slot equal to sample gives same waveform for LSB and MSB.
// - Longer slot: LSB mode aligns bits low, MSB mode aligns high.
// - 24-bit LSB receive reads zero-padded D23..16, then D15..0.
// - 16-bit sample in 32-bit slot: one access, rest driven zero.
// - PCM short or long frame sync chosen by one control bit.
// - Clocks come from core clock, divider, odd bit, mclk enable.
// - No master clock: bit rate is clock over twice divider plus odd.
// - Master clock, 16-bit channels: bit rate divided further by eight.
// - Master clock, 32-bit channels: bit rate divided further by four.
// - No master clock: sample rate divides bit rate by 32 or 64, by 16 or 32 in PCM.
// - Master clock: sample rate is clock over 256 times divisor, 128 times in PCM.
// - Master clock output runs at 256 times sample rate, 128 times in PCM.
// - Four packet types; 16-bit port, wide samples need two accesses.
// - MSB shifted first; left channel always before right.
`timescale 1ns/1ps
module afc_audio_serial (
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    input  wire logic [3:0]  i_avs_address,
    input  wire logic        i_avs_read,
    input  wire logic        i_avs_write,
    input  wire logic [31:0] i_avs_writedata,
    output logic      [31:0] o_avs_readdata,
    output logic             o_avs_waitrequest,
    input  wire logic        i_sd,
    output logic             o_sck,
    output logic             o_ws,
    output logic             o_sd,
    output logic             o_mck
);
    import afc_pkg::*;

    logic [7:0]  ctrl_reg, ctrl_next, div_reg, div_next;
    logic        odd_reg, odd_next, mcken_reg, mcken_next;
    afc_bus_t    bus_reg, bus_next;
    logic [31:0] rdata_reg, rdata_next, hold_reg, hold_next;
    logic        tx_full_reg, tx_full_next, tx_half_reg, tx_half_next;
    logic [11:0] pcnt_reg, pcnt_next;
    logic [8:0]  ucnt_reg, ucnt_next;
    logic [5:0]  bitpos_reg, bitpos_next;
    logic [31:0] smp_reg, smp_next;
    logic        sck_reg, sck_next, ws_reg, ws_next, sd_reg, sd_next;
    logic        mck_reg, mck_next, side_reg, side_next;
    logic [31:0] rxsh_reg, rxsh_next, rxbuf_reg, rxbuf_next;
    logic [1:0]  rxcnt_reg, rxcnt_next;
    // Decoded configuration
    logic        en, pcm, lsb, clen, pol, fsl;
    afc_std_t    fmt;
    logic [5:0]  dl, cb, last, bpn, sn, sc, idx;
    logic [8:0]  dval;
    logic [11:0] per, half;
    logic        upd, smp_ev, tx_load, vbit, acc, pop;
    logic [31:0] txs, cur;
    assign en   = ctrl_reg[C_EN];
    assign fmt  = afc_std_t'(ctrl_reg[C_STD +: 2]);
    assign pcm  = (fmt == STD_PCM);
    assign lsb  = (fmt == STD_LSB);
    assign clen = ctrl_reg[C_CL];
    assign pol  = ctrl_reg[C_POL];
    assign fsl  = ctrl_reg[C_FSL];
    // A 16-bit slot can only carry a 16-bit sample
    assign dl = !clen ? BITS16 :
        (afc_dlen_t'(ctrl_reg[C_DL +: 2]) == DL_24) ? BITS24 :
        (afc_dlen_t'(ctrl_reg[C_DL +: 2]) == DL_32) ? BITS32 : BITS16;
    assign cb   = clen ? BITS32 : BITS16;
    assign last = (pcm ? cb : {cb[4:0], 1'b0}) - 6'h01;
    // Divisor is twice the divider plus the odd bit; below two is unusable
    assign dval = ({div_reg, odd_reg} < MIN_DIV) ? MIN_DIV
                : {div_reg, odd_reg};
    // Bit period in core cycles; one master clock period is dval
    assign per = !mcken_reg ? {3'h0, dval}
               : clen ? {1'b0, dval, 2'h0}
               : {dval, 3'h0};
    assign half   = {1'b0, per[11:1]};
    assign upd    = en && (pcnt_reg == 12'h000);
    assign smp_ev = en && (pcnt_reg == half);
    // Next bit position and its slot index; slot zero starts a channel
    assign bpn = (bitpos_reg >= last) ? 6'h00 : bitpos_reg + 6'h01;
    assign sn  = clen ? {1'b0, bpn[4:0]} : {2'h0, bpn[3:0]};
    assign sc  = clen ? {1'b0, bitpos_reg[4:0]} : {2'h0, bitpos_reg[3:0]};
    assign tx_load = upd && (sn == 6'h00);
    // Halfwords to sample; 24-bit LSB layout differs from the others
    always_comb begin
        if (dl == BITS16)
            txs = {16'h0000, hold_reg[31:16]};
        else if (dl == BITS32)
            txs = hold_reg;
        else if (lsb)
            txs = {8'h00, hold_reg[23:16], hold_reg[15:0]};
        else
            txs = {8'h00, hold_reg[31:16], hold_reg[15:8]};
    end
    // Sample in flight; an empty buffer sends silence rather than stale data
    assign cur  = !tx_load ? smp_reg : tx_full_reg ? txs : 32'h00000000;
    assign vbit = lsb ? (sn >= cb - dl) : (sn < dl);
    assign idx  = lsb ? cb - 6'h01 - sn : dl - 6'h01 - sn;
    // Bus slave, configuration and transmit halfword buffer
    assign acc = (bus_reg == BUS_ACK) && (i_avs_read || i_avs_write);
    assign pop = acc && i_avs_read && (i_avs_address == OFS_DATA)
              && (rxcnt_reg != 2'h0);
    always_comb begin
        bus_next     = bus_reg;
        rdata_next   = rdata_reg;
        ctrl_next    = ctrl_reg;
        div_next     = div_reg;
        odd_next     = odd_reg;
        mcken_next   = mcken_reg;
        hold_next    = hold_reg;
        tx_full_next = tx_full_reg && !tx_load;
        tx_half_next = tx_half_reg;
        unique case (bus_reg)
            BUS_IDLE: begin
                // Data writes stall while a whole sample is still waiting
                if ((i_avs_read || i_avs_write) && !(i_avs_write
                    && i_avs_address == OFS_DATA && tx_full_reg)) begin
                    bus_next = BUS_ACK;
                end
                unique case (i_avs_address)
                    OFS_CTRL: rdata_next = {24'h000000, ctrl_reg};
                    OFS_PSC:  rdata_next = {22'h000000, mcken_reg,
                                            odd_reg, div_reg};
                    OFS_DATA: rdata_next = {16'h0000, rxcnt_reg != 2'h0 ?
                                            rxbuf_reg[31:16] : 16'h0000};
                    OFS_STAT: rdata_next = {28'h0000000, side_reg, en,
                                            rxcnt_reg != 2'h0, !tx_full_reg};
                    default:  rdata_next = 32'h00000000;
                endcase
            end
            BUS_ACK: begin
                bus_next = BUS_IDLE;
                if (acc && i_avs_write) begin
                    unique case (i_avs_address)
                        OFS_CTRL: ctrl_next = i_avs_writedata[7:0];
                        OFS_PSC: begin
                            div_next   = i_avs_writedata[P_DIV +: 8];
                            odd_next   = i_avs_writedata[P_ODD];
                            mcken_next = i_avs_writedata[P_MCK];
                        end
                        OFS_DATA: begin
                            // First access is the high half, then the low
                            if (!tx_half_reg) begin
                                hold_next[31:16] = i_avs_writedata[15:0];
                                tx_full_next = (dl == BITS16);
                                tx_half_next = (dl != BITS16);
                            end else begin
                                hold_next[15:0] = i_avs_writedata[15:0];
                                tx_full_next = 1'b1;
                                tx_half_next = 1'b0;
                            end
                        end
                        default: ;
                    endcase
                end
            end
        endcase
    end
    // Registers of the bus group
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            bus_reg <= BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
            rdata_reg <= 32'h00000000;
            ctrl_reg <= CTRL_RST;
            div_reg <= DIV_RST;
            odd_reg <= 1'b0;
            mcken_reg <= 1'b0;
            hold_reg <= 32'h00000000;
            tx_full_reg <= 1'b0;
            tx_half_reg <= 1'b0;
        end else begin
            bus_reg <= bus_next;
            o_avs_waitrequest <= (bus_next != BUS_ACK);
            rdata_reg <= rdata_next;
            ctrl_reg <= ctrl_next;
            div_reg <= div_next;
            odd_reg <= odd_next;
            mcken_reg <= mcken_next;
            hold_reg <= hold_next;
            tx_full_reg <= tx_full_next;
            tx_half_reg <= tx_half_next;
        end
    end
    assign o_avs_readdata = rdata_reg;
    // Link timing: bit clock, master clock, word select and data
    always_comb begin
        pcnt_next   = 12'h000;
        ucnt_next   = 9'h000;
        bitpos_next = 6'h3F;
        smp_next    = smp_reg;
        ws_next     = ws_reg;
        sd_next     = sd_reg;
        side_next   = side_reg;
        sck_next    = pol;
        mck_next    = 1'b0;
        if (en) begin
            pcnt_next = (pcnt_reg >= per - 12'h001) ? 12'h000
                      : pcnt_reg + 12'h001;
            ucnt_next = (ucnt_reg >= dval - 9'h001) ? 9'h000
                      : ucnt_reg + 9'h001;
            mck_next = mcken_reg && (ucnt_reg < {1'b0, dval[8:1]});
            // Update edge sits at count zero: falling, or rising for PCM
            sck_next = pol ^ (pcm ? (pcnt_reg < half)
                                  : (pcnt_reg >= half));
            bitpos_next = bitpos_reg;
            if (upd) begin
                bitpos_next = bpn;
                smp_next = cur;
                sd_next = vbit && cur[idx[4:0]];
                if (pcm)
                    ws_next = fsl ? (bpn < LONG_SYNC_BITS)
                                  : (bpn == last);
                else
                    ws_next = (bpn >= cb);
                if (sn == 6'h00)
                    side_next = !pcm && (bpn >= cb);
            end
        end
    end
    // Registers of the link group; all pins come straight from flops
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pcnt_reg <= 12'h000;
            ucnt_reg <= 9'h000;
            bitpos_reg <= 6'h3F;
            smp_reg <= 32'h00000000;
            sck_reg <= 1'b0;
            ws_reg <= 1'b0;
            sd_reg <= 1'b0;
            mck_reg <= 1'b0;
            side_reg <= 1'b0;
        end else begin
            pcnt_reg <= pcnt_next;
            ucnt_reg <= ucnt_next;
            bitpos_reg <= bitpos_next;
            smp_reg <= smp_next;
            sck_reg <= sck_next;
            ws_reg <= ws_next;
            sd_reg <= sd_next;
            mck_reg <= mck_next;
            side_reg <= side_next;
        end
    end
    assign o_sck = sck_reg;
    assign o_ws  = ws_reg;
    assign o_sd  = sd_reg;
    assign o_mck = mck_reg;
    // Receive: shift on the sampling edge, unpack at end of each slot
    always_comb begin
        logic [31:0] raw, rs;
        raw = {rxsh_reg[30:0], i_sd};
        rs  = lsb ? raw : (raw >> (cb - dl));
        rxsh_next  = smp_ev ? raw : rxsh_reg;
        rxbuf_next = rxbuf_reg;
        rxcnt_next = rxcnt_reg;
        if (pop) begin
            rxbuf_next = {rxbuf_reg[15:0], 16'h0000};
            rxcnt_next = rxcnt_reg - 2'h1;
        end
        // Arrival wins over a pop that empties the buffer; else overrun
        if (smp_ev && (sc == cb - 6'h01) && (rxcnt_next == 2'h0)) begin
            rxcnt_next = (dl == BITS16) ? 2'h1 : 2'h2;
            if (dl == BITS16)
                rxbuf_next = {rs[15:0], 16'h0000};
            else if (dl == BITS32)
                rxbuf_next = rs;
            else if (lsb)
                rxbuf_next = {8'h00, rs[23:16], rs[15:0]};
            else
                rxbuf_next = {rs[23:0], 8'h00};
        end
    end
    // Registers of the receive group
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rxsh_reg <= 32'h00000000;
            rxbuf_reg <= 32'h00000000;
            rxcnt_reg <= 2'h0;
        end else begin
            rxsh_reg <= rxsh_next;
            rxbuf_reg <= rxbuf_next;
            rxcnt_reg <= rxcnt_next;
        end
    end
    // Checks
    sequence s_data_wr_full;
        i_avs_write && (i_avs_address == OFS_DATA) && tx_full_reg
        && (bus_reg == BUS_IDLE);
    endsequence
    sequence s_lsb24_first_read;
        acc && i_avs_read && (i_avs_address == OFS_DATA) && lsb
        && (dl == BITS24) && (rxcnt_reg == 2'h2);
    endsequence
    default clocking cb_chk @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);
    a_msb_edge_fall: assert property (en && fmt == STD_MSB && $stable(pol)
        && ($changed(o_ws) || $changed(o_sd)) |-> o_sck == pol)
        else $error("MSB mode pins moved off the falling edge");
    a_lsb_edge_fall: assert property (en && lsb && $stable(pol)
        && ($changed(o_ws) || $changed(o_sd)) |-> o_sck == pol)
        else $error("LSB mode pins moved off the falling edge");
    a_pcm_edge_rise: assert property (en && pcm && $stable(pol)
        && ($changed(o_ws) || $changed(o_sd)) |-> o_sck != pol)
        else $error("PCM pins moved off the rising edge");
    a_bit_period_wrap: assert property (en && $stable(per)
        && pcnt_reg == per - 12'h001 |=> (upd || !en) ##1 !upd)
        else $error("Bit period does not match the divisor");
    a_bit_rate_mult: assert property (en |-> per == (!mcken_reg ?
        {3'h0, dval} : 12'(dval * (clen ? 9'h004 : 9'h008))))
        else $error("Bit period multiplier wrong for channel length");
    a_mck_rise_sync: assert property (en && mcken_reg && $stable(dval)
        && $rose(o_mck) |-> ucnt_reg == 9'h001)
        else $error("Master clock not aligned to its divisor");
    a_pad_zero_bits: assert property (upd && !vbit |=> !o_sd)
        else $error("Bit outside the sample is not zero");
    a_short_sync_pos: assert property (en && pcm && !fsl && o_ws
        && $stable(ctrl_reg) |-> bitpos_reg == last)
        else $error("Short frame sync not one bit before data");
    a_tx_wr_stall: assert property (s_data_wr_full
        |=> o_avs_waitrequest)
        else $error("Data write accepted while sample pending");
    a_rx_lsb24_pad: assert property (s_lsb24_first_read
        |-> o_avs_readdata[15:8] == 8'h00)
        else $error("LSB 24-bit first halfword not zero padded");
endmodule : afc_audio_serial

/* sim/afc_codec_model.sv */
/*
 * Behavioural external codec in slave role: returns one fixed word per
 * channel on the serial data input of the framer.
 * Assumes the framer is bit-clock master; i_upd is the update level.
 */
`timescale 1ns/1ps
module afc_codec_model (
    input  wire logic        i_clk,
    input  wire logic        i_sck,
    input  wire logic        i_ws,
    input  wire logic        i_en,
    input  wire logic        i_upd,
    input  wire logic [31:0] i_left,
    input  wire logic [31:0] i_right,
    output logic             o_sd
);
    int   idx  = 0;
    logic side = 1'b0;
    logic tog  = 1'b0;

    // Released line toggles so a stale bit never reads as valid
    always @(posedge i_clk) begin
        tog <= ~tog;
    end

    // Step on the update edge, once word select has settled
    always @(i_sck) begin
        #1;
        if (i_en && i_sck === i_upd) begin
            idx = (i_ws !== side) ? 0 : idx + 1;
            side = i_ws;
        end
    end

    // Link off: next slot starts at bit 31 of the left word
    always @(negedge i_en) begin
        idx = 0;
        side = 1'b0;
    end

    // Most significant bit first, left word while word select is low
    assign o_sd = !i_en ? tog :
                  side ? i_right[5'(31 - idx)] : i_left[5'(31 - idx)];
endmodule : afc_codec_model

/* sim/tb_top.sv */
/*
 * Self-checking bench of the serial audio framer: framing, packing,
 * receive path and clock rates, seen at the pins and the register bus.
 * Assumes the framer is master and the codec model sits on the link.
 */
`timescale 1ns/1ps
module tb_top;
    import afc_pkg::*;
    localparam logic [5:0]  TXT [10] = '{6'h01, 6'h21, 6'h02, 6'h15, 6'h16,
                                        6'h39, 6'h1A, 6'h11, 6'h32, 6'h17};
    localparam logic [10:0] RT  [4] = '{11'h003, 11'h503, 11'h302, 11'h702};
    logic        i_clk     = 1'b0;
    logic        i_reset_n = 1'b0;
    logic [3:0]  adr       = 4'h0;
    logic        rd        = 1'b0;
    logic        wr        = 1'b0;
    logic [31:0] wd        = 32'h0;
    logic [31:0] rdat, q, sh = 32'h0;
    logic        wreq, sck, ws, sdo, mck, sdi, sck_q, ws_q, sd_q, cws;
    logic        mon_on    = 1'b0;
    logic        upd       = 1'b0;
    logic [5:0]  bits      = 6'h10;
    logic [32:0] expq [$];
    int          fails = 0;
    int          samples_checked = 0;
    int          cnt = 0;

    always #10 i_clk = ~i_clk;

    afc_audio_serial u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_avs_address(adr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wd), .o_avs_readdata(rdat),
        .o_avs_waitrequest(wreq), .i_sd(sdi), .o_sck(sck), .o_ws(ws),
        .o_sd(sdo), .o_mck(mck));
    afc_codec_model u_codec (.i_clk(i_clk), .i_sck(sck), .i_ws(ws),
        .i_en(mon_on), .i_upd(upd), .i_left(32'h5AABCDEF),
        .i_right(32'h3C96E187), .o_sd(sdi));

    task automatic check(input logic [32:0] got, input logic [32:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : finish_test

    // One bus cycle; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [3:0] a,
                       input logic [31:0] d);
        @(posedge i_clk);
        adr <= a;
        wr <= w;
        rd <= ~w;
        wd <= d;
        do @(posedge i_clk); while (wreq !== 1'b0);
        q = rdat;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask : bus

    function automatic logic sig(input int k);
        return (k == 0) ? sck : (k == 1) ? ws : mck;
    endfunction : sig

    // Full period (rise to rise) or high time of a pin, in core cycles
    task automatic meas(input int k, input logic full, output int n);
        n = 0;
        for (int p = 0; p < (full ? 4 : 3); p++) begin
            do begin
                @(posedge i_clk);
                if (p > 1) n++;
            end while (sig(k) !== p[0] && n < 9000);
        end
    endtask : meas

    // Monitor: edge discipline of the link, then slot capture
    always @(posedge i_clk) begin
        if (mon_on && sck !== sck_q && (ws !== ws_q || sdo !== sd_q))
            check(sck, upd);
        if (!mon_on) cnt = 0;
        else if (sck !== sck_q && sck === ~upd) begin
            if (cnt == 0) cws = ws;
            sh = {sh[30:0], sdo};
            cnt++;
            if (cnt == bits) begin
                cnt = 0;
                // Idle zero slots carry no sample and are skipped
                if (sh != 32'h0 && expq.size() > 0)
                    check({cws, sh}, expq.pop_front());
                sh = 32'h0;
            end
        end
        sck_q <= sck;
        ws_q <= ws;
        sd_q <= sdo;
    end

    // Left, right, then left sample for one packet type and polarity
    task automatic tx(input logic [5:0] t);
        logic [31:0] s, sl;
        logic        lsb, d24;
        lsb = (t[1:0] == 2'h2);
        d24 = (t[3:2] == 2'h1);
        upd = t[5] ^ (t[1:0] == 2'h3); // PCM updates on the other edge
        bits = t[4] ? BITS32 : BITS16;
        bus(1'b1, OFS_PSC, 32'h1);
        bus(1'b1, OFS_CTRL, {25'h0, t, 1'b0});
        // Third sample meets a full buffer and must wait for a slot start
        for (int c = 0; c < 3; c++) begin
            s = $urandom | 32'h1;
            case (t[3:2])
                2'h0: sl = (lsb || !t[4]) ? {16'h0, s[15:0]} : {s[15:0], 16'h0};
                2'h1: sl = lsb ? {8'h00, s[23:0]} : {s[23:0], 8'h00};
                default: sl = s;
            endcase
            expq.push_back({c[0] && (t[1:0] != 2'h3), sl});
            if (t[3:2] == 2'h0) bus(1'b1, OFS_DATA, {16'h0, s[15:0]});
            else begin
                bus(1'b1, OFS_DATA, {16'h0, (lsb && d24) ?
                    {s[31:24], sl[23:16]} : sl[31:16]});
                bus(1'b1, OFS_DATA, {16'h0, sl[15:8],
                    sl[7:0] | ((!lsb && d24) ? s[31:24] : 8'h00)});
            end
            if (c == 0) begin
                bus(1'b1, OFS_CTRL, {25'h0, t, 1'b1});
                mon_on = 1'b1;
            end
        end
        for (int w = 0; w < 3000 && expq.size() > 0; w++) @(posedge i_clk);
        check(expq.size(), 0);
        bus(1'b1, OFS_CTRL, 32'h0);
        mon_on = 1'b0;
        $display("tx test %h done", t);
    endtask : tx

    initial begin
        int n, dd, p;
        void'($urandom(72));
        repeat (3) @(posedge i_clk);
        check({wreq, sck, ws, sdo, mck}, 33'h10);
        @(posedge i_clk);
        i_reset_n <= 1'b1;
        bus(1'b0, OFS_CTRL, 32'h0);
        check(q, 33'h0);
        bus(1'b0, OFS_PSC, 32'h0);
        check(q[9:0], 33'h002);
        bus(1'b0, OFS_STAT, 32'h0);
        check(q[S_TXE], 33'h1);
        bus(1'b1, 4'h1, 32'hFFFFFFFF);
        bus(1'b0, 4'h1, 32'h0);
        check(q, 33'h0);
        $display("reset test done");
        // Receive: 24-bit sample right-aligned in a 32-bit slot
        bus(1'b1, OFS_PSC, 32'h2);
        bus(1'b1, OFS_CTRL, 32'h2D);
        mon_on = 1'b1;
        for (int i = 0; i < 2; i++) begin
            do bus(1'b0, OFS_STAT, 32'h0); while (q[S_RXR] !== 1'b1);
            bus(1'b0, OFS_DATA, 32'h0);
            check(q[15:0], i ? 33'hCDEF : 33'h00AB);
        end
        bus(1'b1, OFS_CTRL, 32'h0);
        mon_on = 1'b0;
        $display("rx test done");
        foreach (TXT[i]) tx(TXT[i]);
        // Clock generator: bit, frame and master clock periods
        foreach (RT[i]) begin
            dd = RT[i][7:0] * 2 + RT[i][8];
            p = RT[i][9] ? (RT[i][10] ? 4 : 8) * dd : dd;
            upd = 1'b0;
            bus(1'b1, OFS_PSC, {22'h0, RT[i][9:0]});
            bus(1'b1, OFS_CTRL, {26'h0, RT[i][10], 5'h03});
            mon_on = 1'b1;
            meas(0, 1'b1, n);
            check(n, p);
            meas(1, 1'b1, n);
            check(n, p * (RT[i][10] ? 64 : 32));
            if (RT[i][9]) begin
                meas(2, 1'b1, n);
                check(n * 256, p * (RT[i][10] ? 64 : 32));
            end
            else check(mck, 33'h0);
            bus(1'b1, OFS_CTRL, 32'h0);
            mon_on = 1'b0;
        end
        $display("rate test done");
        // Frame sync: one bit wide, or 13 bits wide when long
        for (int f = 0; f < 2; f++) begin
            upd = 1'b1;
            bus(1'b1, OFS_PSC, 32'h1);
            bus(1'b1, OFS_CTRL, {24'h0, f[0], 7'h07});
            mon_on = 1'b1;
            meas(1, 1'b0, n);
            check(n, f ? 26 : 2);
            meas(1, 1'b1, n);
            check(n, 32);
            bus(1'b1, OFS_CTRL, 32'h0);
            mon_on = 1'b0;
        end
        $display("frame sync test done");
        finish_test();
    end

    // Watchdog at 60000 cycles, well beyond the expected run of under 10000 cycles
    initial begin
        #1200000;
        fails++;
        finish_test();
    end
endmodule : tb_top
